// ---- rtl/status_config_blanking_timer.sv ----
// generic status, configuration and blanking timer register bank
//
// Summary of operation
// [R1] undervoltage flag at status bit 7 follows the supply comparator in real time
// [R2] undervoltage high also raises the global error flag
// [R3] chip-reset flag at bit 6 is set after hardware or software reset
// [R4] chip-reset flag clears only on read-and-clear of the generic status register
// [R5] frame end with bad clock count, bad bus state or stuck data sets bit 5
// [R6] frame error flag stays set until read-and-clear of generic status
// [R7] reserved status and configuration bits read zero and ignore writes
// [R8] a set mask bit removes that channel's drain feedback from global status
// [R9] host toggles the watchdog bit in time; device stays in normal mode
// [R10] missed watchdog toggle drives the device into fail-safe
// [R11] each channel auto-restarts during its own blanking window
// [R12] window used up with fault still present latches channel off, sets flag
// [R13] any latch-off flag raises the global error flag
// [R14] fault gone early freezes the timer and keeps the remaining time
// [R15] only a rewrite of the timer control register, or a software reset to the reset window, restores the full window
// [R16] host may refresh the window repeatedly to stay in auto-restart forever
// [R17] programmed nibble forms counter upper bits, lower bits are all ones
// [R18] counter drops one step per step period, at least one per event
// [R19] programmed zero latches off on the first event
// [R20] any timer control write clears the latch-off flag and resets the timer
`timescale 1ns/10ps
`default_nettype none
module status_config_blanking_timer
    import blank_pkg::*;
#(
    parameter int STEP_CYCLES = blank_pkg::STEP_CYCLES,
    parameter int WDOG_CYCLES = blank_pkg::WDOG_CYCLES
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // decoded register commands from the frame logic
    input  wire logic              cmd_valid,
    input  wire cmd_op_t           cmd_op,
    input  wire logic [5:0]        cmd_addr,
    input  wire logic [7:0]        cmd_wdata,
    input  wire logic              sw_reset,
    output logic [7:0]             rdata,
    output logic                   rdata_valid,
    // serial link pins, watched for frame errors
    input  wire logic              spi_sck,
    input  wire logic              spi_csn,
    input  wire logic              spi_sdi,
    // analog and power stage
    input  wire logic              supply_below_threshold,
    input  wire logic [NUM_CH-1:0] fault_active,
    input  wire logic [NUM_CH-1:0] drain_feedback,
    input  wire logic [NUM_CH-1:0] chan_on,
    // status out
    output logic                   supply_undervoltage_flag,
    output logic                   global_error_flag,
    output logic [NUM_CH-1:0]      latch_off_status,
    output logic [NUM_CH-1:0]      masked_feedback,
    output logic                   fail_safe
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int SYW = 4 + 2 * NUM_CH;
    localparam int WW  = $clog2(WDOG_CYCLES + 1);
    localparam logic [WW-1:0] WD_LAST    = WW'(WDOG_CYCLES - 1);
    localparam logic [4:0]    BITS_OK    = 5'(FRAME_BITS);
    localparam logic [4:0]    BITS_SAT   = 5'h1F;

    typedef struct packed {
        logic [SYW-1:0]    sync1;
        logic [SYW-1:0]    sync2;
        logic              sck_d;
        logic              csn_d;
        logic [4:0]        bits;
        logic              seen0;
        logic              seen1;
        logic              bad_idle;
        logic [4:0]        cfg;
        logic              rst_flag;
        logic              frame_err;
        logic [WW-1:0]     wd_cnt;
        logic              fail_safe;
        logic [7:0]        rdata;
        logic              rdata_valid;
        logic              global_error;
        logic [NUM_CH-1:0] masked_fb;
        logic [NUM_CH-1:0] latch_status;
    } bank_t;

    bank_t s_reg;
    bank_t s_next;

    blank_if bus ();

    // ----------------------------------------------------------------
    // synchronised pin view
    // ----------------------------------------------------------------
    logic              uv_s;
    logic              csn_s;
    logic              sck_s;
    logic              sdi_s;
    logic [NUM_CH-1:0] fault_s;
    logic [NUM_CH-1:0] fb_s;

    assign {uv_s, csn_s, sck_s, sdi_s, fault_s, fb_s} = s_reg.sync2;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic is_write;
    logic is_rdclr;
    logic gs_clear;
    logic wr_lo;
    logic wr_hi;
    logic cfg_wr;
    logic [7:0] status_byte;
    logic [7:0] read_byte;

    assign is_write = cmd_valid && (cmd_op == OP_WRITE);
    assign is_rdclr = cmd_valid && (cmd_op == OP_READ_CLEAR);
    assign gs_clear = is_rdclr && (cmd_addr == ADDR_GENERIC_STATUS);
    assign wr_lo    = is_write && (cmd_addr == ADDR_TIMER_LO);
    assign wr_hi    = is_write && (cmd_addr == ADDR_TIMER_HI);
    assign cfg_wr   = is_write && (cmd_addr == ADDR_CONFIGURATION);

    always_comb begin
        status_byte                   = READ_ZERO; // [R7]
        status_byte[GS_UV_BIT]        = uv_s; // [R1]
        status_byte[GS_RST_BIT]       = s_reg.rst_flag;
        status_byte[GS_FRAME_ERR_BIT] = s_reg.frame_err;
    end

    always_comb begin
        case (cmd_addr)
            ADDR_TIMER_LO:       read_byte = bus.count_nib[7:0];
            ADDR_TIMER_HI:       read_byte = bus.count_nib[15:8];
            ADDR_LATCH_STATUS:   read_byte = {4'h0, bus.latched};
            ADDR_GENERIC_STATUS: read_byte = status_byte;
            ADDR_CONFIGURATION:  read_byte = {3'h0, s_reg.cfg}; // [R7]
            default:             read_byte = READ_ZERO;
        endcase
    end

    // ----------------------------------------------------------------
    // timer channel hookup
    // ----------------------------------------------------------------
    assign bus.wr        = {wr_hi, wr_hi, wr_lo, wr_lo}; // [R20]
    assign bus.wr_nib    = {cmd_wdata, cmd_wdata};
    assign bus.sw_clear  = sw_reset;
    assign bus.fail_safe = s_reg.fail_safe;
    assign bus.fault     = fault_s;
    assign bus.chan_on   = chan_on;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            blank_timer #(
                .CH          (gi),
                .STEP_CYCLES (STEP_CYCLES)
            ) u_timer (
                .clock  (clock),
                .resetn (resetn),
                .bus    (bus.chan)
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic sck_rise;
    logic csn_fall;
    logic csn_rise;
    logic frame_bad;
    logic wd_toggled;
    logic [NUM_CH-1:0] fb_next;

    assign sck_rise   = sck_s && !s_reg.sck_d;
    assign csn_fall   = !csn_s && s_reg.csn_d;
    assign csn_rise   = csn_s && !s_reg.csn_d;
    assign frame_bad  = (s_reg.bits != BITS_OK) || !s_reg.seen0 || !s_reg.seen1
                        || s_reg.bad_idle;
    assign wd_toggled = cfg_wr && (cmd_wdata[CFG_WDOG_BIT] != s_reg.cfg[CFG_WDOG_BIT]);
    assign fb_next    = fb_s & ~s_reg.cfg[CFG_MASK_LSB +: NUM_CH]; // [R8]

    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = {supply_below_threshold, spi_csn, spi_sck, spi_sdi,
                        fault_active, drain_feedback};
        s_next.sync2 = s_reg.sync1;
        s_next.sck_d = sck_s;
        s_next.csn_d = csn_s;

        // frame watch; clock high at select marks the frame bad
        if (csn_fall) begin
            s_next.bits     = 5'h00;
            s_next.seen0    = 1'b0;
            s_next.seen1    = 1'b0;
            s_next.bad_idle = sck_s;
        end else if (!csn_s && sck_rise) begin
            if (s_reg.bits != BITS_SAT) begin
                s_next.bits = s_reg.bits + 5'h01;
            end
            if (sdi_s) begin
                s_next.seen1 = 1'b1;
            end else begin
                s_next.seen0 = 1'b1;
            end
        end

        // set wins over read-and-clear for both sticky flags
        if (gs_clear) begin
            s_next.rst_flag  = 1'b0; // [R4]
            s_next.frame_err = 1'b0; // [R6]
        end
        if (sw_reset) begin
            s_next.rst_flag = 1'b1; // [R3]
        end
        if (csn_rise && frame_bad) begin
            s_next.frame_err = 1'b1; // [R5]
        end

        if (cfg_wr) begin
            s_next.cfg = cmd_wdata[CFG_USED_BITS-1:0]; // [R7]
        end
        if (sw_reset) begin
            s_next.cfg = CONFIG_RESET;
        end

        // watchdog: fail-safe left again on the next toggle
        if (wd_toggled || sw_reset) begin
            s_next.wd_cnt    = '0; // [R9]
            s_next.fail_safe = 1'b0;
        end else if (s_reg.wd_cnt == WD_LAST) begin
            s_next.fail_safe = 1'b1; // [R10]
        end else begin
            s_next.wd_cnt = s_reg.wd_cnt + WW'(1);
        end

        s_next.rdata_valid = cmd_valid;
        if (cmd_valid) begin
            s_next.rdata = read_byte;
        end

        s_next.masked_fb    = fb_next;
        s_next.latch_status = bus.latched;
        s_next.global_error = uv_s || (|bus.latched) || (|fb_next); // [R2] [R13]
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_reg          <= '0;
            s_reg.sync1    <= {4'h5, {(2 * NUM_CH){1'b0}}};
            s_reg.sync2    <= {4'h5, {(2 * NUM_CH){1'b0}}};
            s_reg.csn_d    <= 1'b1;
            s_reg.cfg      <= CONFIG_RESET;
            s_reg.rst_flag <= RST_FLAG_RESET; // [R3]
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata                    = s_reg.rdata;
    assign rdata_valid              = s_reg.rdata_valid;
    assign supply_undervoltage_flag = uv_s;
    assign global_error_flag        = s_reg.global_error;
    assign latch_off_status         = s_reg.latch_status;
    assign masked_feedback          = s_reg.masked_fb;
    assign fail_safe                = s_reg.fail_safe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_UV_GLOBAL: assert property (uv_s |=> global_error_flag) // [R2]
        else $error("undervoltage without global error");
    AST_RST_HOLD: assert property ( // [R4]
        s_reg.rst_flag && !gs_clear |=> s_reg.rst_flag)
        else $error("chip reset flag dropped without read-and-clear");
    AST_RST_CLEAR: assert property ( // [R4]
        gs_clear && !sw_reset |=> !s_reg.rst_flag && rdata[GS_RST_BIT] == $past(s_reg.rst_flag))
        else $error("read-and-clear did not clear chip reset flag");
    AST_FRAME_SET: assert property ( // [R5]
        csn_rise && frame_bad |=> s_reg.frame_err)
        else $error("bad frame not flagged");
    AST_FRAME_HOLD: assert property ( // [R6]
        s_reg.frame_err && !gs_clear |=> s_reg.frame_err)
        else $error("frame error dropped without read-and-clear");
    AST_MASK: assert property ( // [R8]
        s_reg.cfg[CFG_MASK_LSB] |=> !masked_feedback[0])
        else $error("masked feedback still reported");
    AST_LATCH_GLOBAL: assert property ( // [R13]
        |bus.latched |=> global_error_flag && latch_off_status == $past(bus.latched))
        else $error("latch-off not in global status");
    AST_WD_TIMEOUT: assert property ( // [R10]
        s_reg.wd_cnt == WD_LAST && !wd_toggled && !sw_reset |=> fail_safe)
        else $error("watchdog timeout did not enter fail-safe");
    AST_RESERVED: assert property ( // [R7]
        cmd_valid && cmd_addr == ADDR_GENERIC_STATUS |=> rdata[4:0] == 5'h00)
        else $error("reserved status bits not zero");
endmodule
`default_nettype wire

// ---- common/blank_pkg.sv ----
// constants, encodings and types shared by the status, configuration and blanking timer logic
package blank_pkg;

    // ----------------------------------------------------------------
    // sizes and clock
    // ----------------------------------------------------------------
    localparam int NUM_CH      = 4;
    localparam int CLOCK_MHZ   = 25;
    localparam int FRAME_BITS  = 16;
    localparam int STEP_US     = 1000;
    localparam int WDOG_US     = 50000;
    localparam int STEP_CYCLES = STEP_US * CLOCK_MHZ;
    localparam int WDOG_CYCLES = WDOG_US * CLOCK_MHZ;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_TIMER_LO       = 6'h08;
    localparam logic [5:0] ADDR_TIMER_HI       = 6'h09;
    localparam logic [5:0] ADDR_LATCH_STATUS   = 6'h32;
    localparam logic [5:0] ADDR_GENERIC_STATUS = 6'h34;
    localparam logic [5:0] ADDR_CONFIGURATION  = 6'h3F;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int GS_UV_BIT        = 7;
    localparam int GS_RST_BIT       = 6;
    localparam int GS_FRAME_ERR_BIT = 5;
    localparam int CFG_MASK_LSB     = 1;
    localparam int CFG_WDOG_BIT     = 0;
    localparam int CFG_USED_BITS    = 5;

    localparam logic [4:0] CONFIG_RESET     = 5'h00;
    localparam logic       RST_FLAG_RESET   = 1'b1;
    localparam logic [3:0] TIMER_CTRL_RESET = 4'hF;
    localparam logic [3:0] TIMER_LOW_FILL   = 4'hF;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // ----------------------------------------------------------------
    // commands and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ       = 2'h0,
        OP_WRITE      = 2'h1,
        OP_READ_CLEAR = 2'h3
    } cmd_op_t;

    typedef enum logic [1:0] {
        T_IDLE    = 2'h0,
        T_RUN     = 2'h1,
        T_LATCHED = 2'h3
    } timer_state_t;

endpackage

// ---- common/blank_if.sv ----
// signals between the register bank and the per-channel blanking timers
`timescale 1ns/10ps
`default_nettype none
interface blank_if;
    import blank_pkg::*;
    logic [NUM_CH-1:0]   wr;
    logic [NUM_CH*4-1:0] wr_nib;
    logic                sw_clear;
    logic                fail_safe;
    logic [NUM_CH-1:0]   fault;
    logic [NUM_CH-1:0]   chan_on;
    logic [NUM_CH*4-1:0] count_nib;
    logic [NUM_CH-1:0]   latched;

    modport bank (output wr, wr_nib, sw_clear, fail_safe, fault, chan_on,
                  input count_nib, latched);
    modport chan (input wr, wr_nib, sw_clear, fail_safe, fault, chan_on,
                  output count_nib, latched);
endinterface
`default_nettype wire

// ---- rtl/blank_timer.sv ----
// one channel's blanking window timer with latch-off
`timescale 1ns/10ps
`default_nettype none
module blank_timer
    import blank_pkg::*;
#(
    parameter int CH          = 0,
    parameter int STEP_CYCLES = blank_pkg::STEP_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // link to register bank
    blank_if.chan     bus
);
    localparam int SW = $clog2(STEP_CYCLES + 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

    typedef struct packed {
        timer_state_t  st;
        logic [7:0]    count;
        logic          zero_prog;
        logic [SW-1:0] sub;
    } tstate_t;

    tstate_t s_reg;
    tstate_t s_next;

    logic       fault_eff;
    logic [3:0] nib;

    // limp home: no counting and no latch while in fail-safe
    assign fault_eff = bus.fault[CH] && bus.chan_on[CH] && !bus.fail_safe;
    assign nib       = bus.wr_nib[CH*4 +: 4];

    always_comb begin
        s_next = s_reg;
        if (bus.wr[CH]) begin
            s_next.count     = {nib, TIMER_LOW_FILL}; // [R17] [R15] [R20]
            s_next.zero_prog = (nib == 4'h0);
            s_next.st        = T_IDLE;
            s_next.sub       = '0;
        end else if (bus.sw_clear) begin
            s_next.count     = {TIMER_CTRL_RESET, TIMER_LOW_FILL};
            s_next.zero_prog = (TIMER_CTRL_RESET == 4'h0);
            s_next.st        = T_IDLE;
            s_next.sub       = '0;
        end else begin
            case (s_reg.st)
                T_IDLE: begin
                    if (fault_eff) begin
                        if (s_reg.zero_prog || s_reg.count == 8'h00) begin
                            s_next.st = T_LATCHED; // [R19] [R12]
                        end else begin
                            // a short event still costs one whole step
                            s_next.count = s_reg.count - 8'h01; // [R18]
                            s_next.sub   = '0;
                            s_next.st    = T_RUN; // [R11]
                        end
                    end
                end
                T_RUN: begin
                    if (!fault_eff) begin
                        s_next.st = T_IDLE; // [R14]
                    end else if (s_reg.sub == STEP_LAST) begin
                        s_next.sub = '0;
                        if (s_reg.count == 8'h00) begin
                            s_next.st = T_LATCHED; // [R12]
                        end else begin
                            s_next.count = s_reg.count - 8'h01; // [R18]
                        end
                    end else begin
                        s_next.sub = s_reg.sub + SW'(1);
                    end
                end
                T_LATCHED: begin
                    s_next.st = T_LATCHED;
                end
                default: begin
                    s_next.st = T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '{st: T_IDLE, count: {TIMER_CTRL_RESET, TIMER_LOW_FILL},
                       zero_prog: 1'b0, sub: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.count_nib[CH*4 +: 4] = s_reg.count[7:4];
    assign bus.latched[CH]          = (s_reg.st == T_LATCHED);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_WRITE_RELOAD: assert property ( // [R15]
        bus.wr[CH] |=> s_reg.count == {$past(nib), TIMER_LOW_FILL} && !bus.latched[CH])
        else $error("timer write did not reload the window");
    AST_ZERO_LATCH: assert property ( // [R19]
        s_reg.st == T_IDLE && s_reg.zero_prog && fault_eff && !bus.wr[CH] && !bus.sw_clear
        |=> bus.latched[CH])
        else $error("zero window did not latch on first event");
    AST_FIRST_STEP: assert property ( // [R18]
        s_reg.st == T_IDLE && fault_eff && !s_reg.zero_prog && s_reg.count != 8'h00
        && !bus.wr[CH] && !bus.sw_clear |=> s_reg.count == $past(s_reg.count) - 8'h01)
        else $error("fault start did not take one step");
    AST_FREEZE: assert property ( // [R14]
        s_reg.st == T_RUN && !fault_eff && !bus.wr[CH] && !bus.sw_clear
        |=> s_reg.count == $past(s_reg.count) && s_reg.st == T_IDLE)
        else $error("timer not frozen when fault went away");
    AST_LATCH_HOLD: assert property ( // [R12]
        bus.latched[CH] && !bus.wr[CH] && !bus.sw_clear |=> bus.latched[CH])
        else $error("latched channel released without a write");
    AST_FAILSAFE_NO_LATCH: assert property ( // [R11]
        bus.fail_safe && !bus.latched[CH] |=> !bus.latched[CH])
        else $error("channel latched while in fail-safe");
endmodule
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// host side of the serial link: sends frames of a chosen length
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    // serial pins
    output logic spi_sck,
    output logic spi_csn,
    output logic spi_sdi
);
    initial begin
        spi_sck = 1'b0;
        spi_csn = 1'b1;
        spi_sdi = 1'b1;
    end
    // ----------------------------------------
    // frame, mode 0, 320 ns clock, still when idle
    // ----------------------------------------
    task automatic frame(input int n, input logic [15:0] d);
        spi_csn = 1'b0;
        #160;
        for (int i = 0; i < n; i++) begin
            spi_sdi = d[15-i];
            #160 spi_sck = 1'b1;
            #160 spi_sck = 1'b0;
        end
        #160 spi_csn = 1'b1;
        // released line shows the inverse so a stale level is never trusted
        spi_sdi = ~spi_sdi;
    endtask
endmodule
`default_nettype wire

// ---- dv/test_status_config_blanking_timer.sv ----
// self-checking bench of the status, configuration and blanking timer bank
`timescale 1ns/10ps
`default_nettype none
module test_status_config_blanking_timer;
    import blank_pkg::*;
    logic       clock, resetn, cmd_valid, sw_reset, rdata_valid;
    logic       spi_sck, spi_csn, spi_sdi, supply_below_threshold;
    logic       supply_undervoltage_flag, global_error_flag, fail_safe;
    cmd_op_t    cmd_op;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_wdata, rdata, junk;
    logic [3:0] fault_active, drain_feedback, chan_on, latch_off_status, masked_feedback;
    logic [4:0] cfg;
    int         num_errors, n_checks, cycles;

    spi_host_model host (.spi_sck(spi_sck), .spi_csn(spi_csn), .spi_sdi(spi_sdi));
    status_config_blanking_timer #(.STEP_CYCLES(8), .WDOG_CYCLES(64)) dut (
        .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .sw_reset(sw_reset), .rdata(rdata),
        .rdata_valid(rdata_valid), .spi_sck(spi_sck), .spi_csn(spi_csn), .spi_sdi(spi_sdi),
        .supply_below_threshold(supply_below_threshold), .fault_active(fault_active),
        .drain_feedback(drain_feedback), .chan_on(chan_on),
        .supply_undervoltage_flag(supply_undervoltage_flag),
        .global_error_flag(global_error_flag), .latch_off_status(latch_off_status),
        .masked_feedback(masked_feedback), .fail_safe(fail_safe));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input cmd_op_t op, input logic [5:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_wdata = wd;
        @(negedge clock);
        cmd_valid = 1'b0;
        chk("rdata_valid", 8'h01, {7'h00, rdata_valid});
        rd = rdata;
    endtask
    task automatic rc(input cmd_op_t op, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] r;
        cmd(op, a, 8'h00, r);
        chk("rdata", e, r);
    endtask
    task automatic kick;
        cfg[0] = ~cfg[0];
        cmd(OP_WRITE, 6'h3F, {3'h0, cfg}, junk);
    endtask
    // waits k times 32 cycles, toggling the watchdog so timers keep running
    task automatic wait_kick(input int k);
        repeat (k) begin
            repeat (30) @(negedge clock);
            kick();
        end
    endtask
    task automatic bit_chk(input string nm, input logic e, input logic g);
        chk(nm, {7'h00, e}, {7'h00, g});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rc(OP_READ, 6'h34, 8'h40);
        rc(OP_READ, 6'h3F, 8'h00);
        rc(OP_READ_CLEAR, 6'h34, 8'h40);
        cmd(OP_WRITE, 6'h34, 8'hFF, junk);
        rc(OP_READ, 6'h34, 8'h00);
        rc(OP_READ, 6'h20, 8'h00);
        @(negedge clock) sw_reset = 1'b1;
        @(negedge clock) sw_reset = 1'b0;
        rc(OP_READ_CLEAR, 6'h34, 8'h40);
    endtask
    task automatic t_frames;
        int          n[4] = '{15, 16, 16, 16};
        logic [15:0] d[4] = '{16'hA5C3, 16'hFFFF, 16'h0000, 16'hA5C3};
        logic [7:0]  e[4] = '{8'h20, 8'h20, 8'h20, 8'h00};
        for (int i = 0; i < 4; i++) begin
            host.frame(n[i], d[i]);
            repeat (8) @(negedge clock);
            rc(OP_READ, 6'h34, e[i]);
            rc(OP_READ_CLEAR, 6'h34, e[i]);
        end
    endtask
    task automatic t_uv;
        supply_below_threshold = 1'b1;
        repeat (5) @(negedge clock);
        bit_chk("uv_flag", 1'b1, supply_undervoltage_flag);
        bit_chk("global_error", 1'b1, global_error_flag);
        rc(OP_READ_CLEAR, 6'h34, 8'h80);
        supply_below_threshold = 1'b0;
        repeat (5) @(negedge clock);
        bit_chk("uv_flag", 1'b0, supply_undervoltage_flag);
        bit_chk("global_error", 1'b0, global_error_flag);
    endtask
    task automatic t_mask;
        drain_feedback = 4'hA;
        cfg = 5'h1E;
        cmd(OP_WRITE, 6'h3F, 8'hFE, junk);
        rc(OP_READ, 6'h3F, 8'h1E);
        repeat (5) @(negedge clock);
        chk("masked_feedback", 8'h00, {4'h0, masked_feedback});
        bit_chk("global_error", 1'b0, global_error_flag);
        cfg = 5'h10;
        cmd(OP_WRITE, 6'h3F, 8'h10, junk);
        repeat (3) @(negedge clock);
        chk("masked_feedback", 8'h02, {4'h0, masked_feedback});
        bit_chk("global_error", 1'b1, global_error_flag);
        drain_feedback = 4'h0;
    endtask
    task automatic t_timer;
        kick();
        chan_on = 4'h7;
        cmd(OP_WRITE, 6'h08, 8'h01, junk);
        fault_active[1] = 1'b1;
        repeat (6) @(negedge clock);
        chk("latch_off", 8'h02, {4'h0, latch_off_status});
        bit_chk("global_error", 1'b1, global_error_flag);
        rc(OP_READ, 6'h32, 8'h02);
        fault_active[1] = 1'b0;
        cmd(OP_WRITE, 6'h08, 8'h01, junk);
        repeat (3) @(negedge clock);
        chk("latch_off", 8'h00, {4'h0, latch_off_status});
        fault_active[0] = 1'b1;
        wait_kick(2);
        fault_active[0] = 1'b0;
        wait_kick(3);
        rc(OP_READ, 6'h08, 8'h01);
        fault_active[0] = 1'b1;
        wait_kick(4);
        chk("latch_off", 8'h00, {4'h0, latch_off_status});
        rc(OP_READ, 6'h08, 8'h00);
        wait_kick(3);
        chk("latch_off", 8'h01, {4'h0, latch_off_status});
        fault_active[0] = 1'b0;
        cmd(OP_WRITE, 6'h08, 8'h01, junk);
        chk("old_timer", 8'h00, junk);
        rc(OP_READ, 6'h08, 8'h01);
        chk("latch_off", 8'h00, {4'h0, latch_off_status});
        fault_active[2] = 1'b1;
        repeat (3) begin
            cmd(OP_WRITE, 6'h09, 8'h01, junk);
            wait_kick(6);
        end
        chk("latch_off", 8'h00, {4'h0, latch_off_status});
        wait_kick(3);
        chk("latch_off", 8'h04, {4'h0, latch_off_status});
    endtask
    task automatic t_watchdog;
        wait_kick(3);
        bit_chk("fail_safe", 1'b0, fail_safe);
        repeat (80) @(negedge clock);
        bit_chk("fail_safe", 1'b1, fail_safe);
        kick();
        repeat (2) @(negedge clock);
        bit_chk("fail_safe", 1'b0, fail_safe);
    endtask
    // ----------------------------------------
    // main sequence and hang limit
    // ----------------------------------------
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        {num_errors, n_checks, cycles} = '0;
        {resetn, cmd_valid, sw_reset, supply_below_threshold} = '0;
        {cmd_addr, cmd_wdata, fault_active, drain_feedback, chan_on, cfg} = '0;
        cmd_op = OP_READ;
        repeat (4) @(posedge clock);
        @(negedge clock) resetn = 1'b1;
        t_reset();
        t_frames();
        t_uv();
        t_mask();
        t_timer();
        t_watchdog();
        end_sim();
    end
endmodule
`default_nettype wire
